// ### hdl/cgic_ctrl.v
// Purpose: Per-channel caption insert and contact-bit controller
// Assumes: One clock, inputs synchronous except raw contacts
// Notes: Video datapath lives outside; this block steers it
`timescale 1ns/1ps
`default_nettype none
`include "cgic_defs.vh"

// Operation
// [RULE1] Report measured format and lock, read-only
// [RULE2] Programmable HD and SD caption lines
// [RULE3] Select clean/monitor output arrangement
// [RULE4] Blank captions from none or one contact
// [RULE5] Per-input transmit polarity
// [RULE6] Per-output receive polarity
// [RULE7] Each output picks any received bit
// [RULE8] Map transmit pins to encoded bits
// [RULE9] Encode contact bits only when enabled
// [RULE10] Timeout in seconds, zero to fifteen
// [RULE11] Normal mode reverts after timeout; permanent keeps
// [RULE12] Separate SD and HD contact-data lines
// [RULE13] Service number accepts only 1 to 63
// [RULE14] Analog field even first, odd second
// [RULE15] Aspect ratio flag output
// [RULE16] Easy-reader flag output
// [RULE17] Analog or digital caption flag
// [RULE18] Programmable language code, default eng
// [RULE19] Suppress caption insert without packets
// [RULE20] Optional ancillary captions in SD
// [RULE21] Decoder output packaged or raw
// [RULE22] Optionally omit digital packets from decoder
// [RULE23] Synchronise and debounce contact inputs
module cgic_ctrl #(
    parameter DEBOUNCE_CYC = `CGIC_DEBOUNCE_CYC,
    parameter SECOND_CYC = `CGIC_CLK_HZ
) (
    // Clock and reset
    input wire clk,
    input wire reset_n,
    // Avalon-MM slave
    input wire [5:0] avs_address,
    input wire avs_read,
    input wire avs_write,
    input wire [31:0] avs_writedata,
    input wire [3:0] avs_byteenable,
    output reg [31:0] avs_readdata,
    output wire avs_waitrequest,
    // Measured video state
    input wire [7:0] video_format,
    input wire video_locked,
    input wire video_is_hd,
    input wire field_second,
    input wire packets_present,
    input wire new_encode_data,
    // Received bits, first channel in [3:0], second in [7:4]
    input wire [7:0] received_bit_outputs,
    // External contacts
    input wire [3:0] contact_input,
    output reg [3:0] contact_output,
    // Control toward the video path
    output reg [10:0] caption_line,
    output reg [10:0] gp_line,
    output reg channel_clean_output,
    output reg channel_monitor_output,
    output reg caption_blank,
    output reg caption_insert_en,
    output reg sd_anc_insert_en,
    output reg [3:0] transmit_bit_inputs,
    output reg [3:0] second_transmit_bits,
    output reg gp_insert_en,
    output reg aspect_wide,
    output reg easy_reader,
    output reg digital_type,
    output reg analog_field_odd,
    output reg [5:0] service_number,
    output reg [23:0] language_code,
    output reg decoder_raw,
    output reg decoder_omit_digital
);

    // ======================================================
    // Configuration registers
    reg [10:0] hd_line_reg;
    reg [10:0] sd_caption_line_reg;
    reg [1:0] out_sel_reg;
    reg [2:0] blank_sel_reg;
    reg no_cdp_off_reg;
    reg sd_anc_reg;
    reg raw_fmt_reg;
    reg omit_dig_reg;
    reg easy_reg;
    reg aspect_reg;
    reg digital_reg;
    reg [5:0] svc_reg;
    reg [23:0] lang_reg;
    reg [3:0] tx_pol_reg;
    reg [3:0] rx_pol_reg;
    reg gp_en_reg;
    reg [3:0] timeout_reg;
    reg [1:0] mode_reg;
    reg [10:0] gp_sd_line_reg;
    reg [10:0] gp_hd_line_reg;
    reg [31:0] mapping_reg;
    reg svc_reject_reg;
    reg timed_out_reg;
    reg [3:0] contact_level_reg;
    reg rd_wait_reg;

    wire wr_strobe = avs_write;
    // Writes answer at once; reads stall one cycle
    assign avs_waitrequest = avs_read && !rd_wait_reg;

    // ======================================================
    // Register writes
    always @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            hd_line_reg <= 11'h000;
            sd_caption_line_reg <= 11'h000;
            out_sel_reg <= `CGIC_OUT_NORMAL;
            blank_sel_reg <= 3'h0;
            no_cdp_off_reg <= 1'b0;
            sd_anc_reg <= 1'b0;
            raw_fmt_reg <= 1'b0;
            omit_dig_reg <= 1'b0;
            easy_reg <= 1'b0;
            aspect_reg <= 1'b0;
            digital_reg <= 1'b0;
            svc_reg <= `CGIC_RST_SVC;
            svc_reject_reg <= 1'b0;
            lang_reg <= `CGIC_RST_LANG;
            tx_pol_reg <= 4'h0;
            rx_pol_reg <= 4'hf;
            gp_en_reg <= 1'b0;
            timeout_reg <= 4'h0;
            mode_reg <= `CGIC_MODE_NORMAL;
            gp_sd_line_reg <= 11'h000;
            gp_hd_line_reg <= 11'h000;
            mapping_reg <= `CGIC_RST_MAPPING;
        end else if (wr_strobe) begin
            case (avs_address)
                `CGIC_OFS_LINES: begin
                    hd_line_reg <= avs_writedata[10:0]; // RULE2
                    sd_caption_line_reg <= avs_writedata[26:16];
                end
                `CGIC_OFS_OPTIONS: begin
                    if (avs_writedata[1:0] != 2'h3) begin
                        out_sel_reg <= avs_writedata[1:0]; // RULE3
                    end
                    if (avs_writedata[6:4] <= 3'h4) begin
                        blank_sel_reg <= avs_writedata[6:4]; // RULE4
                    end
                    no_cdp_off_reg <= avs_writedata[8]; // RULE19
                    sd_anc_reg <= avs_writedata[9]; // RULE20
                    raw_fmt_reg <= avs_writedata[10]; // RULE21
                    omit_dig_reg <= avs_writedata[11]; // RULE22
                end
                `CGIC_OFS_META: begin
                    easy_reg <= avs_writedata[0]; // RULE16
                    aspect_reg <= avs_writedata[1]; // RULE15
                    digital_reg <= avs_writedata[2]; // RULE17
                    // Out-of-range numbers leave the old value
                    if (avs_writedata[13:8] >= `CGIC_SVC_MIN &&
                        avs_writedata[13:8] <= `CGIC_SVC_MAX) begin
                        svc_reg <= avs_writedata[13:8]; // RULE13
                        svc_reject_reg <= 1'b0;
                    end else begin
                        svc_reject_reg <= 1'b1; // RULE13
                    end
                end
                `CGIC_OFS_LANG: begin
                    lang_reg <= avs_writedata[23:0]; // RULE18
                end
                `CGIC_OFS_GPI: begin
                    tx_pol_reg <= avs_writedata[3:0]; // RULE5
                    rx_pol_reg <= avs_writedata[7:4]; // RULE6
                    gp_en_reg <= avs_writedata[8]; // RULE9
                    timeout_reg <= avs_writedata[15:12]; // RULE10
                    mode_reg <= avs_writedata[17:16]; // RULE11
                end
                `CGIC_OFS_GPLINES: begin
                    gp_sd_line_reg <= avs_writedata[10:0]; // RULE12
                    gp_hd_line_reg <= avs_writedata[26:16];
                end
                `CGIC_OFS_MAPPING: begin
                    mapping_reg <= avs_writedata; // RULE7 RULE8
                end
                default: begin
                    svc_reject_reg <= svc_reject_reg;
                end
            endcase
        end
    end

    // ======================================================
    // Register reads; status is read-only, writes ignored
    always @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            avs_readdata <= 32'h0000_0000;
        end else if (avs_waitrequest) begin
            case (avs_address)
                `CGIC_OFS_STATUS: avs_readdata <= {21'h0, timed_out_reg,
                    svc_reject_reg, video_locked, video_format}; // RULE1
                `CGIC_OFS_LINES: avs_readdata <= {5'h0, sd_caption_line_reg,
                    5'h0, hd_line_reg};
                `CGIC_OFS_OPTIONS: avs_readdata <= {20'h0, omit_dig_reg,
                    raw_fmt_reg, sd_anc_reg, no_cdp_off_reg, 1'b0,
                    blank_sel_reg, 2'h0, out_sel_reg};
                `CGIC_OFS_META: avs_readdata <= {18'h0, svc_reg, 5'h0,
                    digital_reg, aspect_reg, easy_reg};
                `CGIC_OFS_LANG: avs_readdata <= {8'h0, lang_reg};
                `CGIC_OFS_GPI: avs_readdata <= {14'h0, mode_reg,
                    timeout_reg, 3'h0, gp_en_reg, rx_pol_reg, tx_pol_reg};
                `CGIC_OFS_GPLINES: avs_readdata <= {5'h0, gp_hd_line_reg,
                    5'h0, gp_sd_line_reg};
                `CGIC_OFS_MAPPING: avs_readdata <= mapping_reg;
                `CGIC_OFS_RXBITS: avs_readdata <= {20'h0, contact_level_reg,
                    received_bit_outputs};
                default: avs_readdata <= `CGIC_RST_UNMAPPED;
            endcase
        end
    end

    // Read wait state: registered word must stand
    // at the edge that accepts the read
    always @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            rd_wait_reg <= 1'b0;
        end else begin
            rd_wait_reg <= avs_waitrequest;
        end
    end

    // ======================================================
    // Contact synchroniser and debounce, one per input
    genvar gi;
    generate
        for (gi = 0; gi < 4; gi = gi + 1) begin : g_contact
            reg sync0_reg;
            reg sync1_reg;
            reg [31:0] stable_cnt_reg;
            always @(posedge clk or negedge reset_n) begin
                if (!reset_n) begin
                    sync0_reg <= 1'b1;
                    sync1_reg <= 1'b1;
                    stable_cnt_reg <= 32'h0;
                    contact_level_reg[gi] <= 1'b1;
                end else begin
                    sync0_reg <= contact_input[gi]; // RULE23
                    sync1_reg <= sync0_reg;
                    // Level must hold steady to beat contact bounce
                    if (sync1_reg == contact_level_reg[gi]) begin
                        stable_cnt_reg <= 32'h0;
                    end else if (stable_cnt_reg >= DEBOUNCE_CYC - 1) begin
                        contact_level_reg[gi] <= sync1_reg; // RULE23
                        stable_cnt_reg <= 32'h0;
                    end else begin
                        stable_cnt_reg <= stable_cnt_reg + 32'h1;
                    end
                end
            end
        end
    endgenerate

    // Polarity: clear bit means low (closed) is asserted
    wire [3:0] tx_asserted = contact_level_reg ~^ tx_pol_reg; // RULE5

    // ======================================================
    // Insertion timeout, whole seconds
    reg [31:0] sec_cnt_reg;
    reg [3:0] secs_reg;
    always @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            sec_cnt_reg <= 32'h0;
            secs_reg <= 4'h0;
            timed_out_reg <= 1'b0;
        end else if (new_encode_data || !gp_en_reg) begin
            sec_cnt_reg <= 32'h0;
            secs_reg <= 4'h0;
            timed_out_reg <= 1'b0;
        end else if (secs_reg >= timeout_reg) begin
            // Zero seconds expires at once
            timed_out_reg <= 1'b1; // RULE10
        end else if (sec_cnt_reg >= SECOND_CYC - 1) begin
            sec_cnt_reg <= 32'h0;
            secs_reg <= secs_reg + 4'h1;
        end else begin
            sec_cnt_reg <= sec_cnt_reg + 32'h1;
        end
    end

    // Permanent modes ignore the timeout; field modes pick a field
    reg insert_now;
    always @* begin
        case (mode_reg)
            `CGIC_MODE_NORMAL: insert_now = !timed_out_reg; // RULE11
            `CGIC_MODE_PERM_F0: insert_now = !field_second;
            `CGIC_MODE_PERM_F1: insert_now = field_second;
            default: insert_now = 1'b1;
        endcase
    end

    // ======================================================
    // Mapping: each 2-bit field selects a transmit lane; receive picks use 3-bit fields
    reg [3:0] map_a;
    reg [3:0] map_b;
    reg [3:0] rx_pick;
    integer k;
    always @* begin
        map_a = 4'h0;
        map_b = 4'h0;
        rx_pick = 4'h0;
        for (k = 0; k < 4; k = k + 1) begin
            map_a[k] = tx_asserted[mapping_reg[2*k +: 2]]; // RULE8
            map_b[k] = tx_asserted[mapping_reg[8 + 2*k +: 2]];
            // Three-bit select spans both channels
            rx_pick[k] = received_bit_outputs[mapping_reg[16 + 3*k +: 3]]; // RULE7
        end
    end

    // ======================================================
    // Output drive
    always @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            contact_output <= 4'h0;
            caption_line <= 11'h000;
            gp_line <= 11'h000;
            channel_clean_output <= 1'b1;
            // Reset matches the normal arrangement
            channel_monitor_output <= 1'b1;
            caption_blank <= 1'b0;
            caption_insert_en <= 1'b0;
            sd_anc_insert_en <= 1'b0;
            transmit_bit_inputs <= 4'h0;
            second_transmit_bits <= 4'h0;
            gp_insert_en <= 1'b0;
            aspect_wide <= 1'b0;
            easy_reader <= 1'b0;
            digital_type <= 1'b0;
            analog_field_odd <= 1'b0;
            service_number <= `CGIC_RST_SVC;
            language_code <= `CGIC_RST_LANG;
            decoder_raw <= 1'b0;
            decoder_omit_digital <= 1'b0;
        end else begin
            // Active-high drives the set bit high
            contact_output <= ~(rx_pick ^ rx_pol_reg); // RULE6
            caption_line <= video_is_hd ? hd_line_reg :
                sd_caption_line_reg; // RULE2
            gp_line <= video_is_hd ? gp_hd_line_reg :
                gp_sd_line_reg; // RULE12
            channel_clean_output <= (out_sel_reg != `CGIC_OUT_BURN); // RULE3
            channel_monitor_output <= (out_sel_reg != `CGIC_OUT_CLEAN);
            // Select code minus one names the contact lane
            caption_blank <= (blank_sel_reg != 3'h0) &&
                tx_asserted[blank_sel_reg[1:0] - 2'h1]; // RULE4
            caption_insert_en <= !(no_cdp_off_reg && !packets_present); // RULE19
            sd_anc_insert_en <= sd_anc_reg && !video_is_hd; // RULE20
            transmit_bit_inputs <= map_a;
            second_transmit_bits <= map_b;
            gp_insert_en <= gp_en_reg && insert_now; // RULE9
            aspect_wide <= aspect_reg;
            easy_reader <= easy_reg;
            digital_type <= digital_reg;
            analog_field_odd <= field_second; // RULE14
            service_number <= svc_reg;
            language_code <= lang_reg;
            decoder_raw <= raw_fmt_reg;
            decoder_omit_digital <= omit_dig_reg;
        end
    end

endmodule
`default_nettype wire

// ### hdl/cgic_defs.vh
// Purpose: Register map and constants for the caption/contact-bit controller
// Assumes: Avalon-MM slave, 32-bit data, word-aligned byte addresses
// Notes: Definitions only
`ifndef CGIC_DEFS_VH
`define CGIC_DEFS_VH

// ==========================================================
// Register byte offsets
`define CGIC_OFS_STATUS 6'h00
`define CGIC_OFS_LINES 6'h04
`define CGIC_OFS_OPTIONS 6'h08
`define CGIC_OFS_META 6'h0c
`define CGIC_OFS_LANG 6'h10
`define CGIC_OFS_GPI 6'h14
`define CGIC_OFS_GPLINES 6'h18
`define CGIC_OFS_MAPPING 6'h1c
`define CGIC_OFS_RXBITS 6'h20

// ==========================================================
// Field positions and codes
`define CGIC_OUT_NORMAL 2'h0
`define CGIC_OUT_CLEAN 2'h1
`define CGIC_OUT_BURN 2'h2
`define CGIC_MODE_NORMAL 2'h0
`define CGIC_MODE_PERM_F0 2'h1
`define CGIC_MODE_PERM_F1 2'h2
`define CGIC_MODE_PERM_BOTH 2'h3
`define CGIC_SVC_MIN 6'h01
`define CGIC_SVC_MAX 6'h3f
`define CGIC_TIMEOUT_MAX 4'hf

// ==========================================================
// Reset values and unmapped read word
`define CGIC_RST_LANG 24'h656e67
`define CGIC_RST_SVC 6'h01
`define CGIC_RST_MAPPING 32'h0000_e4e4
`define CGIC_RST_UNMAPPED 32'hdead_beef

// ==========================================================
// Timing
`define CGIC_CLK_HZ 10000000
`define CGIC_DEBOUNCE_NS 1000000
`define CGIC_CLK_NS 100
`define CGIC_DEBOUNCE_CYC (`CGIC_DEBOUNCE_NS / `CGIC_CLK_NS)

`endif

// ### verif/cgic_ctrl_bench.sv
// Purpose: Directed register tests of the caption controller
// Assumes: Readdata taken at the edge that accepts the read
// Notes: Short debounce and second counts keep the run brief
`timescale 1ns/1ps
`default_nettype none
`define chk(a, b) begin n_compared++; if ((a) !== (b)) begin \
    err_total++; $display("BAD t=%0t got %h exp %h", $time, a, b); end end
module cgic_ctrl_bench;
    // =========================================
    // Stimulus and observed signals
    logic clk = 1'b0;
    logic reset_n = 1'b0;
    logic [5:0] avs_address = 6'h00;
    logic avs_read = 1'b0, avs_write = 1'b0;
    logic [31:0] avs_writedata = 32'h0, rdat;
    logic [7:0] video_format = 8'h00, rx_set = 8'h00;
    logic video_locked = 1'b0, video_is_hd = 1'b0;
    logic packets_present = 1'b0, new_encode_data = 1'b0;
    logic [3:0] sw_closed = 4'h0;
    int err_total = 0, n_compared = 0;
    wire [31:0] avs_readdata;
    wire [10:0] caption_line, gp_line;
    wire [7:0] rx_bits;
    wire [3:0] contacts, contact_output, tx_a, tx_b;
    wire [5:0] service_number;
    wire [23:0] language_code;
    wire waitreq, field, clean_out, mon_out, blank, cap_en, anc_en, gp_en;
    wire aspect, easy, digital, field_odd, raw, omit;
    cgic_video_model model_u (.clk(clk), .reset_n(reset_n),
        .sw_closed(sw_closed), .rx_set(rx_set), .field_second(field),
        .received_bit_outputs(rx_bits), .contact_input(contacts));
    cgic_ctrl #(.DEBOUNCE_CYC(4), .SECOND_CYC(20)) dut_u (.clk(clk),
        .reset_n(reset_n), .avs_address(avs_address), .avs_read(avs_read),
        .avs_write(avs_write), .avs_writedata(avs_writedata),
        .avs_byteenable(4'hf), .avs_readdata(avs_readdata),
        .avs_waitrequest(waitreq), .video_format(video_format),
        .video_locked(video_locked), .video_is_hd(video_is_hd),
        .field_second(field), .packets_present(packets_present),
        .new_encode_data(new_encode_data), .received_bit_outputs(rx_bits),
        .contact_input(contacts), .contact_output(contact_output),
        .caption_line(caption_line), .gp_line(gp_line),
        .channel_clean_output(clean_out), .channel_monitor_output(mon_out),
        .caption_blank(blank), .caption_insert_en(cap_en),
        .sd_anc_insert_en(anc_en), .transmit_bit_inputs(tx_a),
        .second_transmit_bits(tx_b), .gp_insert_en(gp_en),
        .aspect_wide(aspect), .easy_reader(easy), .digital_type(digital),
        .analog_field_odd(field_odd), .service_number(service_number),
        .language_code(language_code), .decoder_raw(raw),
        .decoder_omit_digital(omit));
    // =========================================
    // Bus tasks; request held until waitrequest low
    task automatic bus(input logic rd_en, input logic [5:0] a,
        input logic [31:0] d);
        int n;
        @(posedge clk);
        avs_read <= rd_en;
        avs_write <= !rd_en;
        avs_address <= a;
        avs_writedata <= d;
        n = 0;
        do begin
            @(posedge clk);
            n++;
        end while (waitreq !== 1'b0 && n < 50);
        rdat = avs_readdata;
        avs_read <= 1'b0;
        avs_write <= 1'b0;
        if (n >= 50) begin
            err_total++;
            wrap_up();
        end
    endtask
    // Write, then let outputs settle
    task automatic wr(input logic [5:0] a, input logic [31:0] d);
        bus(1'b0, a, d);
        cyc(4);
    endtask
    task automatic rd(input logic [5:0] a);
        bus(1'b1, a, 32'h0);
    endtask
    task automatic cyc(input int n);
        repeat (n) @(posedge clk);
    endtask
    task automatic pulse();
        new_encode_data <= 1'b1;
        @(posedge clk);
        new_encode_data <= 1'b0;
    endtask
    // Wait for a second field to start, then let outputs follow
    task automatic wait_rise();
        int n;
        logic was;
        n = 0;
        was = 1'b1;
        while (!(was === 1'b0 && field === 1'b1) && n < 40) begin
            was = field;
            @(posedge clk);
            n++;
        end
        cyc(2);
        if (n >= 40) begin
            err_total++;
            wrap_up();
        end
    endtask
    task automatic wrap_up();
        $display("compared %0d mismatches %0d", n_compared, err_total);
        if (err_total == 0 && n_compared > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask
    // =========================================
    // Clock, watchdog and main sequence
    initial begin
        forever #50 clk = ~clk;
    end
    initial begin
        cyc(5000);
        err_total++;
        wrap_up();
    end
    initial begin
        cyc(6);
        reset_n <= 1'b1;
        cyc(2);
        `chk(clean_out, 1'b1)
        `chk(service_number, 6'h01)
        rd(6'h10);
        `chk(rdat[23:0], 24'h656e67)
        video_format <= 8'h5a;
        video_locked <= 1'b1;
        wr(6'h00, 32'h0);
        rd(6'h00);
        `chk(rdat[8:0], 9'h15a)
        video_is_hd <= 1'b1;
        wr(6'h04, 32'h0015_0009);
        wr(6'h18, 32'h0007_0012);
        `chk(caption_line, 11'h009)
        `chk(gp_line, 11'h007)
        video_is_hd <= 1'b0;
        cyc(4);
        `chk(caption_line, 11'h015)
        `chk(gp_line, 11'h012)
        for (int k = 0; k < 3; k++) begin
            wr(6'h08, 32'(k));
            `chk(clean_out, k != 2)
            `chk(mon_out, k != 1)
        end
        // Blank from contact two, all option bits set
        wr(6'h08, 32'h0000_0f20);
        `chk(cap_en, 1'b0)
        `chk(anc_en, 1'b1)
        `chk(raw, 1'b1)
        `chk(omit, 1'b1)
        packets_present <= 1'b1;
        sw_closed <= 4'h2;
        cyc(2);
        sw_closed <= 4'h0;
        cyc(12);
        `chk(cap_en, 1'b1)
        `chk(blank, 1'b0)
        sw_closed <= 4'h2;
        cyc(20);
        `chk(blank, 1'b1)
        wr(6'h14, 32'h2);
        `chk(blank, 1'b0)
        wr(6'h14, 32'h0);
        wr(6'h08, 32'h0);
        `chk(blank, 1'b0)
        wr(6'h0c, 32'h0000_3f07);
        `chk({easy, aspect}, 2'h3)
        `chk({digital, service_number}, 7'h7f)
        wr(6'h0c, 32'h0);
        `chk({easy, digital, service_number}, 8'h3f)
        rd(6'h00);
        `chk(rdat[9], 1'b1)
        wr(6'h10, 32'h0066_7261);
        `chk(language_code, 24'h667261)
        // Reversed pin map, output zero from second channel bit one
        sw_closed <= 4'h1;
        rx_set <= 8'h20;
        wr(6'h14, 32'h0000_01f0);
        wr(6'h1c, 32'h0005_e41b);
        cyc(12);
        `chk(tx_a, 4'h8)
        `chk(tx_b, 4'h1)
        `chk(contact_output, 4'h1)
        wr(6'h14, 32'h0000_0100);
        `chk(contact_output, 4'he)
        rd(6'h20);
        `chk(rdat[11:0], 12'he20)
        // Longest timeout, then a permanent mode
        wr(6'h14, 32'h0000_f100);
        pulse();
        cyc(4);
        `chk(gp_en, 1'b1)
        cyc(266);
        rd(6'h00);
        `chk(rdat[10], 1'b0)
        cyc(60);
        rd(6'h00);
        `chk(rdat[10], 1'b1)
        `chk(gp_en, 1'b0)
        wr(6'h14, 32'h0003_f100);
        pulse();
        cyc(340);
        `chk(gp_en, 1'b1)
        // Field-locked permanent modes
        wr(6'h14, 32'h0001_0100);
        wait_rise();
        `chk({gp_en, field_odd}, 2'h1)
        wr(6'h14, 32'h0002_0100);
        wait_rise();
        `chk({gp_en, field_odd}, 2'h3)
        wr(6'h14, 32'h0);
        `chk(gp_en, 1'b0)
        rd(6'h24);
        `chk(rdat, 32'hdeadbeef)
        wrap_up();
    end
endmodule
`default_nettype wire

// ### verif/cgic_ctrl_props.sv
// Purpose: Bus and control relations of the caption controller
// Assumes: Bound to cgic_ctrl, one clock, reset_n async low
// Notes: Config rebuilt from bus writes where a relation needs it
`timescale 1ns/1ps
`default_nettype none
module cgic_ctrl_props (
    // Clock and reset
    input wire logic clk,
    input wire logic reset_n,
    // Register bus
    input wire logic [5:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [31:0] avs_writedata,
    input wire logic [31:0] avs_readdata,
    input wire logic avs_waitrequest,
    // Video side
    input wire logic [7:0] video_format,
    input wire logic video_locked,
    input wire logic video_is_hd,
    input wire logic field_second,
    // Control outputs
    input wire logic [10:0] caption_line,
    input wire logic [10:0] gp_line,
    input wire logic [5:0] service_number,
    input wire logic analog_field_odd,
    input wire logic gp_insert_en,
    input wire logic [23:0] language_code
);
    logic gpi_en_reg;
    logic [31:0] wdata_reg;
    wire wr_lines = avs_write && avs_address == 6'h04;
    wire wr_gpl = avs_write && avs_address == 6'h18;
    wire wr_meta = avs_write && avs_address == 6'h0c;
    wire wr_lang = avs_write && avs_address == 6'h10;
    default clocking @(posedge clk); endclocking
    default disable iff (!reset_n);
    // =========================================
    // Shadow of last write and insertion enable
    always @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            gpi_en_reg <= 1'b0;
            wdata_reg <= 32'h0;
        end else if (avs_write) begin
            wdata_reg <= avs_writedata;
            if (avs_address == 6'h14)
                gpi_en_reg <= avs_writedata[8];
        end
    end
    // =========================================
    // Relations
    status_mirror_a: assert property (avs_read && !avs_waitrequest &&
        avs_address == 6'h00 |->
        avs_readdata[8:0] == {$past(video_locked), $past(video_format)})
        else $error("status word does not mirror video input");
    cap_line_a: assert property (wr_lines ##1
        (!avs_write && $stable(video_is_hd))[*3] |-> caption_line ==
        (video_is_hd ? wdata_reg[10:0] : wdata_reg[26:16]))
        else $error("caption line does not follow format");
    gp_line_a: assert property (wr_gpl ##1
        (!avs_write && $stable(video_is_hd))[*3] |-> gp_line ==
        (video_is_hd ? wdata_reg[26:16] : wdata_reg[10:0]))
        else $error("contact data line does not follow format");
    svc_range_a: assert property (service_number != 6'h00)
        else $error("service number left its range");
    svc_keep_a: assert property (wr_meta && avs_writedata[13:8] == 6'h00
        ##1 !avs_write[*3] |-> service_number == $past(service_number, 3))
        else $error("service number zero was taken");
    field_track_a: assert property (
        (reset_n && $stable(field_second))[*3] |->
        analog_field_odd == field_second) else $error("field flag stale");
    gp_gate_a: assert property (!gpi_en_reg[*3] |-> !gp_insert_en)
        else $error("contact insertion while disabled");
    lang_copy_a: assert property (wr_lang ##1 !avs_write[*3]
        |-> language_code == wdata_reg[23:0])
        else $error("language code not taken");
endmodule
bind cgic_ctrl cgic_ctrl_props props_u (.clk(clk), .reset_n(reset_n),
    .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
    .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest),
    .video_format(video_format), .video_locked(video_locked),
    .video_is_hd(video_is_hd), .field_second(field_second),
    .caption_line(caption_line), .gp_line(gp_line),
    .service_number(service_number), .analog_field_odd(analog_field_odd),
    .gp_insert_en(gp_insert_en), .language_code(language_code));
`default_nettype wire

// ### verif/cgic_video_model.sv
// Purpose: Far side: incoming video bits and switch contacts
// Assumes: Contacts are switches to ground with pull-ups
// Notes: Field flips every eight cycles, a tiny frame
`timescale 1ns/1ps
`default_nettype none
module cgic_video_model (
    // Clock and reset
    input wire logic clk,
    input wire logic reset_n,
    // Scene from the bench
    input wire logic [3:0] sw_closed,
    input wire logic [7:0] rx_set,
    // Toward the controller
    output logic field_second,
    output logic [7:0] received_bit_outputs,
    output logic [3:0] contact_input
);
    logic [2:0] line_reg;
    // Pull-up reads high while a switch is open
    assign contact_input = ~sw_closed;
    // Field count and decoded bits move on the clock
    always @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            line_reg <= 3'h0;
            field_second <= 1'b0;
            received_bit_outputs <= 8'h00;
        end else begin
            line_reg <= line_reg + 3'h1;
            received_bit_outputs <= rx_set;
            if (line_reg == 3'h7)
                field_second <= ~field_second;
        end
    end
endmodule
`default_nettype wire
